// ### hw/hafh_pkg.sv
// Purpose: Shared constants and types for the HDLC address field handler.
// Assumes: Byte-wide register port with one-cycle read latency.
// Notes: Offsets are byte addresses of the register port.
package hafh_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_TX_ADDR_HIGH = 8'h3E;
    localparam logic [7:0] OFF_TX_ADDR_LOW = 8'h3F;
    localparam logic [7:0] OFF_RX_ONE_LOW = 8'h40;
    localparam logic [7:0] OFF_RX_ONE_HIGH = 8'h41;
    localparam logic [7:0] OFF_RX_TWO_LOW = 8'h42;
    localparam logic [7:0] OFF_RX_TWO_HIGH = 8'h43;
    localparam logic [7:0] OFF_RX_ONE_LOW_MASK = 8'h44;
    localparam logic [7:0] OFF_RX_ONE_HIGH_MASK = 8'h45;
    localparam logic [7:0] OFF_RX_TWO_LOW_MASK = 8'h46;
    localparam logic [7:0] OFF_RX_TWO_HIGH_MASK = 8'h47;
    localparam logic [7:0] OFF_CHANNEL_CONFIG = 8'h50;
    localparam logic [7:0] OFF_RX_STATUS = 8'h51;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam int CR_BIT = 1;
    localparam int EXT_BIT = 0;
    // Channel config and receive status field positions.
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_SIZE_BIT = 2;
    localparam int STA_CR_BIT = 0;
    localparam int STA_MATCH_ONE_BIT = 1;
    localparam int STA_MATCH_TWO_BIT = 2;
    localparam int STA_ACCEPT_BIT = 3;

    typedef enum logic [1:0] {
        HAFH_MODE_TRANSPARENT = 2'h0,
        HAFH_MODE_AUTO = 2'h1,
        HAFH_MODE_ADDR_ONE = 2'h2,
        HAFH_MODE_ADDR_TWO = 2'h3
    } hafh_mode_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } hafh_bus_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] addr;
    } hafh_rx_addr_t;
endpackage : hafh_pkg

// ### hw/hafh_top.sv
// Purpose: HDLC address field insertion on transmit and recognition on receive.
// Assumes: All inputs synchronous to CLK_SYS_I; framer asks for an address per frame.
// Notes: Transmit address is presented as a registered 16-bit field plus a length flag.
// Operation
// (RULE_01) Transmit addresses used only in automatic modes
// (RULE_02) Insert programmed address into each frame
// (RULE_03) Size bit selects one or two bytes
// (RULE_04) Two bytes: high register first, low second
// (RULE_05) Software writes high byte bit 1 zero
// (RULE_06) Device drives command/response bit by polarity
// (RULE_07) Software should write extension bit zero
// (RULE_08) One byte: commands send high register
// (RULE_09) One byte: responses send low register
// (RULE_10) Compare received bytes with programmed addresses
// (RULE_11) Per-bit masks apply in all recognizing modes
// (RULE_12) Mask one matches; mask zero must equal
// (RULE_13) Automatic mode: receive high bit 1 is polarity
// (RULE_14) Status reports command/response per polarity
// (RULE_15) Software zeroes receive high one, byte mode
// (RULE_16) Sixteen bit: first low is low byte
// (RULE_17) Eight bit: commands match first low
// (RULE_18) Second address; responses match second low
// (RULE_19) Accept on either masked match
`timescale 1ns/1ps
module hafh_top (
    // Clock, reset and enable
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    input wire logic CE_I,
    // Register port
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [7:0] REG_RDATA_O,
    // Transmit side
    input wire logic TX_REQ_I,
    input wire logic TX_IS_RESPONSE_I,
    output logic TX_VALID_O,
    output logic TX_ADDR_USE_O,
    output logic TX_TWO_BYTES_O,
    output logic [15:0] TX_ADDR_O,
    // Receive side
    input wire logic RX_VALID_I,
    input wire logic [15:0] RX_ADDR_I,
    output logic RX_DONE_O,
    output logic RX_ACCEPT_O,
    output logic [7:0] RX_STATUS_O
);
    hafh_pkg::hafh_bus_req_t req;
    hafh_pkg::hafh_rx_addr_t rxa;
    hafh_pkg::hafh_mode_t mode;
    logic [7:0] tx_high_reg;
    logic [7:0] tx_low_reg;
    logic [7:0] rx_one_low_reg;
    logic [7:0] rx_one_high_reg;
    logic [7:0] rx_two_low_reg;
    logic [7:0] rx_two_high_reg;
    logic [7:0] mask_one_low_reg;
    logic [7:0] mask_one_high_reg;
    logic [7:0] mask_two_low_reg;
    logic [7:0] mask_two_high_reg;
    logic [7:0] config_reg;
    logic [7:0] status_reg;
    logic [7:0] rdata_next;
    logic two_bytes;
    logic auto_mode;
    logic addr_mode;
    logic polarity;
    logic [15:0] ref_one;
    logic [15:0] ref_two;
    logic [15:0] msk_one;
    logic [15:0] msk_two;
    logic [15:0] cmp_one;
    logic [15:0] cmp_two;
    logic match_one;
    logic match_two;
    logic rx_cr;
    logic rx_is_cmd;
    logic [7:0] tx_high_cr;
    logic cr_tx;

    assign req = '{wr: REG_WR_I, rd: REG_RD_I, addr: REG_ADDR_I, wdata: REG_WDATA_I};
    assign rxa = '{valid: RX_VALID_I, addr: RX_ADDR_I};
    assign mode = hafh_pkg::hafh_mode_t'(config_reg[hafh_pkg::CFG_MODE_LSB +: 2]);
    assign two_bytes = config_reg[hafh_pkg::CFG_SIZE_BIT]; // [RULE_03]
    assign auto_mode = (mode == hafh_pkg::HAFH_MODE_AUTO);
    // Address handling is off only in transparent mode.
    assign addr_mode = (mode != hafh_pkg::HAFH_MODE_TRANSPARENT); // [RULE_01]
    // Polarity lives in the receive high register only in the automatic mode.
    assign polarity = auto_mode & rx_one_high_reg[hafh_pkg::CR_BIT]; // [RULE_13]

    // Register writes.
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            tx_high_reg <= hafh_pkg::REG_RESET;
            tx_low_reg <= hafh_pkg::REG_RESET;
            rx_one_low_reg <= hafh_pkg::REG_RESET;
            rx_one_high_reg <= hafh_pkg::REG_RESET;
            rx_two_low_reg <= hafh_pkg::REG_RESET;
            rx_two_high_reg <= hafh_pkg::REG_RESET;
            mask_one_low_reg <= hafh_pkg::REG_RESET;
            mask_one_high_reg <= hafh_pkg::REG_RESET;
            mask_two_low_reg <= hafh_pkg::REG_RESET;
            mask_two_high_reg <= hafh_pkg::REG_RESET;
            config_reg <= hafh_pkg::REG_RESET;
        end else if (CE_I && req.wr) begin
            unique case (req.addr)
                hafh_pkg::OFF_TX_ADDR_HIGH: tx_high_reg <= req.wdata;
                hafh_pkg::OFF_TX_ADDR_LOW: tx_low_reg <= req.wdata;
                hafh_pkg::OFF_RX_ONE_LOW: rx_one_low_reg <= req.wdata;
                hafh_pkg::OFF_RX_ONE_HIGH: rx_one_high_reg <= req.wdata;
                hafh_pkg::OFF_RX_TWO_LOW: rx_two_low_reg <= req.wdata;
                hafh_pkg::OFF_RX_TWO_HIGH: rx_two_high_reg <= req.wdata;
                hafh_pkg::OFF_RX_ONE_LOW_MASK: mask_one_low_reg <= req.wdata;
                hafh_pkg::OFF_RX_ONE_HIGH_MASK: mask_one_high_reg <= req.wdata;
                hafh_pkg::OFF_RX_TWO_LOW_MASK: mask_two_low_reg <= req.wdata;
                hafh_pkg::OFF_RX_TWO_HIGH_MASK: mask_two_high_reg <= req.wdata;
                hafh_pkg::OFF_CHANNEL_CONFIG: config_reg <= {5'h00, req.wdata[2:0]};
                default: begin
                end
            endcase
        end
    end

    // Read mux; unmapped offsets read as zero.
    always_comb begin
        unique case (req.addr)
            hafh_pkg::OFF_TX_ADDR_HIGH: rdata_next = tx_high_reg;
            hafh_pkg::OFF_TX_ADDR_LOW: rdata_next = tx_low_reg;
            hafh_pkg::OFF_RX_ONE_LOW: rdata_next = rx_one_low_reg;
            hafh_pkg::OFF_RX_ONE_HIGH: rdata_next = rx_one_high_reg;
            hafh_pkg::OFF_RX_TWO_LOW: rdata_next = rx_two_low_reg;
            hafh_pkg::OFF_RX_TWO_HIGH: rdata_next = rx_two_high_reg;
            hafh_pkg::OFF_RX_ONE_LOW_MASK: rdata_next = mask_one_low_reg;
            hafh_pkg::OFF_RX_ONE_HIGH_MASK: rdata_next = mask_one_high_reg;
            hafh_pkg::OFF_RX_TWO_LOW_MASK: rdata_next = mask_two_low_reg;
            hafh_pkg::OFF_RX_TWO_HIGH_MASK: rdata_next = mask_two_high_reg;
            hafh_pkg::OFF_CHANNEL_CONFIG: rdata_next = config_reg;
            hafh_pkg::OFF_RX_STATUS: rdata_next = status_reg;
            default: rdata_next = hafh_pkg::UNMAPPED_READ;
        endcase
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            REG_RDATA_O <= hafh_pkg::REG_RESET;
        end else if (CE_I) begin
            REG_RDATA_O <= req.rd ? rdata_next : hafh_pkg::REG_RESET;
        end
    end

    // Register port checks: writes land one edge after the strobe, reads stand one cycle.
    cfg_write_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE_03]
        CE_I && req.wr && req.addr == hafh_pkg::OFF_CHANNEL_CONFIG
        |=> config_reg == ($past(REG_WDATA_I) & 8'h07))
        else $error("Config write did not land.");

    tx_high_write_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE_04]
        CE_I && req.wr && req.addr == hafh_pkg::OFF_TX_ADDR_HIGH
        |=> tx_high_reg == $past(REG_WDATA_I))
        else $error("Transmit high write did not land.");

    tx_low_write_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE_04]
        CE_I && req.wr && req.addr == hafh_pkg::OFF_TX_ADDR_LOW
        |=> tx_low_reg == $past(REG_WDATA_I))
        else $error("Transmit low write did not land.");

    rd_idle_zero_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        CE_I && !req.rd |=> REG_RDATA_O == 8'h00)
        else $error("Read data not zero without a read.");

    rd_cfg_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE_03]
        CE_I && req.rd && req.addr == hafh_pkg::OFF_CHANNEL_CONFIG
        |=> REG_RDATA_O[7:3] == 5'h00)
        else $error("Unused config bits read back set.");

    rd_status_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE_14]
        CE_I && req.rd && req.addr == hafh_pkg::OFF_RX_STATUS
        |=> REG_RDATA_O == $past(status_reg))
        else $error("Status read is wrong.");

    // A low enable must hold the transmit, receive-one and config registers, or a slow caller would see lost writes.
    ce_freeze_regs_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        !CE_I |=> $stable({tx_high_reg, tx_low_reg, rx_one_low_reg, rx_one_high_reg, config_reg}))
        else $error("Registers moved while enable was low.");

    ce_freeze_rd_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        !CE_I |=> $stable(REG_RDATA_O))
        else $error("Read data moved while enable was low.");

    // Transmit: command bit is polarity, response bit its inverse.
    assign cr_tx = TX_IS_RESPONSE_I ? ~polarity : polarity; // [RULE_06]
    always_comb begin
        tx_high_cr = tx_high_reg;
        tx_high_cr[hafh_pkg::CR_BIT] = cr_tx; // [RULE_06]
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            TX_VALID_O <= 1'b0;
            TX_ADDR_USE_O <= 1'b0;
            TX_TWO_BYTES_O <= 1'b0;
            TX_ADDR_O <= 16'h0000;
        end else if (CE_I) begin
            TX_VALID_O <= TX_REQ_I;
            if (TX_REQ_I) begin
                TX_ADDR_USE_O <= addr_mode; // [RULE_01] [RULE_02]
                TX_TWO_BYTES_O <= two_bytes;
                if (!addr_mode) begin
                    TX_ADDR_O <= 16'h0000; // [RULE_01]
                end else if (two_bytes) begin
                    TX_ADDR_O <= {tx_high_cr, tx_low_reg}; // [RULE_04]
                end else if (TX_IS_RESPONSE_I) begin
                    TX_ADDR_O <= {8'h00, tx_low_reg}; // [RULE_09]
                end else begin
                    TX_ADDR_O <= {8'h00, tx_high_reg}; // [RULE_08]
                end
            end
        end
    end

    tx_valid_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE_02]
        CE_I |=> TX_VALID_O == $past(TX_REQ_I))
        else $error("Transmit valid is not one cycle after the request.");

    tx_hold_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE_02]
        CE_I && !TX_REQ_I |=> $stable(TX_ADDR_O))
        else $error("Transmit address changed without a request.");

    tx_size_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE_03]
        CE_I && TX_REQ_I |=> TX_TWO_BYTES_O == $past(config_reg[hafh_pkg::CFG_SIZE_BIT]))
        else $error("Transmit size flag is wrong.");

    tx_use_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE_01]
        CE_I && TX_REQ_I && addr_mode |=> TX_ADDR_USE_O)
        else $error("Address not used in an addressing mode.");

    tx_high_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE_04]
        CE_I && TX_REQ_I && addr_mode && two_bytes
        |=> (TX_ADDR_O[15:8] & 8'hFD) == ($past(tx_high_reg) & 8'hFD))
        else $error("High transmit byte is wrong.");

    ce_freeze_tx_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        !CE_I |=> $stable(TX_ADDR_O) && $stable(TX_VALID_O))
        else $error("Transmit outputs moved while enable was low.");

    // Receive references. In byte mode address one catches commands, two responses.
    assign ref_one = two_bytes ? {rx_one_high_reg, rx_one_low_reg} : {8'h00, rx_one_low_reg};
    assign ref_two = two_bytes ? {rx_two_high_reg, rx_two_low_reg} : {8'h00, rx_two_low_reg};
    // The command/response position never takes part in the automatic-mode compare.
    assign msk_one = two_bytes ? {mask_one_high_reg | {6'h00, auto_mode, 1'b0},
                                  mask_one_low_reg} : {8'hFF, mask_one_low_reg};
    assign msk_two = two_bytes ? {mask_two_high_reg | {6'h00, auto_mode, 1'b0},
                                  mask_two_low_reg} : {8'hFF, mask_two_low_reg};

    genvar b;
    generate
        for (b = 0; b < 16; b++) begin : g_cmp
            assign cmp_one[b] = msk_one[b] | (rxa.addr[b] == ref_one[b]); // [RULE_12]
            assign cmp_two[b] = msk_two[b] | (rxa.addr[b] == ref_two[b]); // [RULE_11]
        end
    endgenerate

    assign match_one = &cmp_one; // [RULE_10] [RULE_16] [RULE_17]
    assign match_two = &cmp_two; // [RULE_18]
    // A command shows as the inverse of polarity. A one-byte field has no such bit,
    // so there a match on address one stands for a received command.
    assign rx_cr = two_bytes ? rxa.addr[8 + hafh_pkg::CR_BIT] : (match_one ^ polarity);
    assign rx_is_cmd = (rx_cr != polarity); // [RULE_14]

    rx_byte_one_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE_17]
        rxa.valid && !two_bytes && rxa.addr[7:0] == rx_one_low_reg |-> match_one)
        else $error("Command address not matched.");

    rx_byte_two_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE_18]
        rxa.valid && !two_bytes && rxa.addr[7:0] == rx_two_low_reg |-> match_two)
        else $error("Response address not matched.");

    rx_word_one_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE_16]
        rxa.valid && two_bytes && rxa.addr == {rx_one_high_reg, rx_one_low_reg} |-> match_one)
        else $error("First address not matched.");

    rx_word_two_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE_18]
        rxa.valid && two_bytes && rxa.addr == {rx_two_high_reg, rx_two_low_reg} |-> match_two)
        else $error("Second address not matched.");

    rx_mask_two_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE_11]
        rxa.valid && !two_bytes && mask_two_low_reg == 8'h00
        && rxa.addr[7:0] != rx_two_low_reg |-> !match_two)
        else $error("Unmasked mismatch on address two.");

    rx_auto_cr_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE_13]
        rxa.valid && auto_mode && two_bytes && mask_one_high_reg == 8'h00
        && mask_one_low_reg == 8'h00
        && (rxa.addr ^ {rx_one_high_reg, rx_one_low_reg}) == 16'h0200 |-> match_one)
        else $error("Polarity bit took part in the compare.");

    rx_full_high_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE_13]
        rxa.valid && two_bytes && !auto_mode && mask_one_high_reg == 8'h00
        && rxa.addr[9] != rx_one_high_reg[1] |-> !match_one)
        else $error("High address bit 1 ignored outside automatic mode.");

    rx_cmd_byte_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE_14]
        rxa.valid && !two_bytes |-> rx_is_cmd == match_one)
        else $error("Byte-mode command not tied to address one.");

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            status_reg <= hafh_pkg::REG_RESET;
            RX_DONE_O <= 1'b0;
            RX_ACCEPT_O <= 1'b0;
        end else if (CE_I) begin
            RX_DONE_O <= rxa.valid;
            if (rxa.valid) begin
                RX_ACCEPT_O <= ~addr_mode | match_one | match_two; // [RULE_19]
                status_reg <= '0;
                status_reg[hafh_pkg::STA_CR_BIT] <= rx_cr; // [RULE_14]
                status_reg[hafh_pkg::STA_MATCH_ONE_BIT] <= match_one;
                status_reg[hafh_pkg::STA_MATCH_TWO_BIT] <= match_two;
                status_reg[hafh_pkg::STA_ACCEPT_BIT] <= ~addr_mode | match_one | match_two;
            end
        end
    end
    assign RX_STATUS_O = status_reg;

    rx_done_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE_10]
        CE_I |=> RX_DONE_O == $past(rxa.valid))
        else $error("Receive done is not one cycle after valid.");

    rx_hold_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE_19]
        CE_I && !rxa.valid |=> $stable(RX_ACCEPT_O))
        else $error("Accept changed without a frame.");

    rx_open_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE_19]
        CE_I && rxa.valid && !addr_mode |=> RX_ACCEPT_O)
        else $error("Transparent mode refused a frame.");

    rx_status_byte_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE_14]
        CE_I && rxa.valid && !two_bytes
        |=> (status_reg[hafh_pkg::STA_CR_BIT] != $past(polarity)) == $past(match_one))
        else $error("Byte-mode status command bit is wrong.");

    rx_status_acc_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE_19]
        CE_I && rxa.valid |=> status_reg[hafh_pkg::STA_ACCEPT_BIT] == RX_ACCEPT_O)
        else $error("Status accept bit disagrees with accept.");

    // Status is read-only; only a received frame may change it.
    status_ro_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE_14]
        CE_I && !rxa.valid |=> $stable(status_reg))
        else $error("Status changed without a frame.");

    ce_freeze_rx_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        !CE_I |=> $stable(status_reg) && $stable(RX_ACCEPT_O) && $stable(RX_DONE_O))
        else $error("Receive outputs moved while enable was low.");

    accept_rule_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE_19]
        CE_I && rxa.valid && addr_mode |=> RX_ACCEPT_O == $past(match_one | match_two))
        else $error("Accept does not follow address match.");
    tx_order_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE_04]
        CE_I && TX_REQ_I && addr_mode && two_bytes |=> TX_ADDR_O[7:0] == $past(tx_low_reg))
        else $error("Low transmit byte is wrong.");
    tx_cr_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE_06]
        CE_I && TX_REQ_I && addr_mode && two_bytes
        |=> TX_ADDR_O[9] == ($past(TX_IS_RESPONSE_I) ^ $past(polarity)))
        else $error("Command/response bit is wrong.");
    tx_cmd_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE_08]
        CE_I && TX_REQ_I && addr_mode && !two_bytes && !TX_IS_RESPONSE_I
        |=> TX_ADDR_O == {8'h00, $past(tx_high_reg)})
        else $error("Command address is wrong.");
    tx_resp_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE_09]
        CE_I && TX_REQ_I && addr_mode && !two_bytes && TX_IS_RESPONSE_I
        |=> TX_ADDR_O == {8'h00, $past(tx_low_reg)})
        else $error("Response address is wrong.");
    tx_off_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE_01]
        CE_I && TX_REQ_I && !addr_mode |=> !TX_ADDR_USE_O && TX_ADDR_O == 16'h0000)
        else $error("Address used outside automatic modes.");
    rx_exact_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE_12]
        rxa.valid && !two_bytes && mask_one_low_reg == 8'h00
        && rxa.addr[7:0] != rx_one_low_reg |-> !match_one)
        else $error("Unmasked mismatch accepted.");
    rx_status_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [RULE_14]
        CE_I && rxa.valid && two_bytes |=> status_reg[0] == $past(rxa.addr[9]))
        else $error("Status command/response bit is wrong.");
endmodule : hafh_top

// ### test/hafh_remote_model.sv
// Purpose: Remote station model that hands received frame addresses to the block.
// Assumes: One address per frame, launched by the bench one cycle ahead.
// Notes: Between frames the address lines toggle so stale values never look valid.
`timescale 1ns/1ps
module hafh_remote_model (
    // Clock
    input wire logic clk_i,
    // Bench command
    input wire logic send_i,
    input wire logic [15:0] frame_addr_i,
    // Towards the block
    output logic rx_valid_o = 1'b0,
    output logic [15:0] rx_addr_o = 16'h0000
);
    always @(posedge clk_i) begin
        rx_valid_o <= send_i;
        rx_addr_o <= send_i ? frame_addr_i : ~rx_addr_o;
    end
endmodule : hafh_remote_model

// ### test/tb_top.sv
// Purpose: Self-checking bench for the HDLC address field handler.
// Assumes: Fixed latencies of the register, transmit and receive ports.
// Notes: Clock enable is dropped once to check that state freezes.
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic tx_req = 1'b0;
    logic tx_resp = 1'b0;
    logic send = 1'b0;
    logic [15:0] frame = 16'h0000;
    logic [7:0] reg_rdata;
    logic tx_valid, tx_use, tx_two, rx_valid, rx_done, rx_accept;
    logic [15:0] tx_addr, rx_addr;
    logic [7:0] rx_status;
    int n_fail = 0;
    int samples_checked = 0;

    always #4 clk = ~clk;

    hafh_remote_model i_remote (.clk_i(clk), .send_i(send), .frame_addr_i(frame),
        .rx_valid_o(rx_valid), .rx_addr_o(rx_addr));
    hafh_top i_dut (.CLK_SYS_I(clk), .RST_I(rst), .CE_I(ce), .REG_ADDR_I(reg_addr),
        .REG_WDATA_I(reg_wdata), .REG_WR_I(reg_wr), .REG_RD_I(reg_rd), .REG_RDATA_O(reg_rdata),
        .TX_REQ_I(tx_req), .TX_IS_RESPONSE_I(tx_resp), .TX_VALID_O(tx_valid),
        .TX_ADDR_USE_O(tx_use), .TX_TWO_BYTES_O(tx_two), .TX_ADDR_O(tx_addr),
        .RX_VALID_I(rx_valid), .RX_ADDR_I(rx_addr), .RX_DONE_O(rx_done),
        .RX_ACCEPT_O(rx_accept), .RX_STATUS_O(rx_status));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rdc

    task automatic cfg(input logic [1:0] mode, input logic two);
        wr(hafh_pkg::OFF_CHANNEL_CONFIG, {5'h00, two, mode});
    endtask : cfg

    task automatic tx(input logic resp, input logic [15:0] exp, input logic two, input logic u);
        @(posedge clk);
        tx_req <= 1'b1;
        tx_resp <= resp;
        @(posedge clk);
        tx_req <= 1'b0;
        #1;
        chk(tx_valid, 16'h0001);
        chk(tx_use, u);
        if (u) chk(tx_two, two);
        chk(tx_addr, exp);
        @(posedge clk);
        #1;
        chk(tx_valid, 16'h0000);
    endtask : tx

    task automatic rx(input logic [15:0] a, input logic acc, input logic [7:0] sta);
        @(posedge clk);
        send <= 1'b1;
        frame <= a;
        @(posedge clk);
        send <= 1'b0;
        @(posedge clk);
        #1;
        chk(rx_done, 16'h0001);
        chk(rx_accept, acc);
        chk(rx_status, sta);
    endtask : rx

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : wrap_up

    // A hang is cut short here and counted as a failure.
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        wrap_up();
    end

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 10; i++) rdc(8'h3E + 8'(i), 8'h00);
        wr(8'h30, 8'hFF);
        rdc(8'h30, 8'h00);
        wr(8'h51, 8'hFF);
        rdc(8'h51, 8'h00);
        for (int i = 0; i < 10; i++) wr(8'h3E + 8'(i), 8'hA5 ^ 8'(i));
        for (int i = 0; i < 10; i++) rdc(8'h3E + 8'(i), 8'hA5 ^ 8'(i));
        wr(hafh_pkg::OFF_CHANNEL_CONFIG, 8'hFF);
        rdc(hafh_pkg::OFF_CHANNEL_CONFIG, 8'h07);
        $display("register test done");
        wr(8'h3E, 8'hFC);
        wr(8'h3F, 8'h5A);
        wr(8'h41, 8'h02);
        cfg(2'h0, 1'b1);
        tx(1'b0, 16'h0000, 1'b1, 1'b0);
        for (int m = 1; m < 4; m++) begin
            cfg(2'(m), 1'b1);
            tx(1'b0, (m == 1) ? 16'hFE5A : 16'hFC5A, 1'b1, 1'b1);
            tx(1'b1, (m == 1) ? 16'hFC5A : 16'hFE5A, 1'b1, 1'b1);
        end
        wr(8'h41, 8'h00);
        cfg(2'h1, 1'b1);
        tx(1'b0, 16'hFC5A, 1'b1, 1'b1);
        tx(1'b1, 16'hFE5A, 1'b1, 1'b1);
        cfg(2'h1, 1'b0);
        tx(1'b0, 16'h00FC, 1'b0, 1'b1);
        tx(1'b1, 16'h005A, 1'b0, 1'b1);
        $display("transmit test done");
        wr(8'h40, 8'h34);
        wr(8'h41, 8'h12);
        wr(8'h42, 8'h78);
        wr(8'h43, 8'h56);
        for (int i = 4; i < 8; i++) wr(8'h40 + 8'(i), 8'h00);
        cfg(2'h3, 1'b1);
        rx(16'h1234, 1'b1, 8'h0B);
        rx(16'h5678, 1'b1, 8'h0D);
        rx(16'h1035, 1'b0, 8'h00);
        wr(8'h44, 8'h0F);
        wr(8'h46, 8'h07);
        rx(16'h123F, 1'b1, 8'h0B);
        rx(16'h567F, 1'b1, 8'h0D);
        rx(16'h12BF, 1'b0, 8'h01);
        wr(8'h44, 8'h00);
        wr(8'h46, 8'h00);
        cfg(2'h1, 1'b1);
        rx(16'h1034, 1'b1, 8'h0A);
        wr(8'h41, 8'h00);
        cfg(2'h1, 1'b0);
        rx(16'hAB34, 1'b1, 8'h0B);
        rx(16'hAB78, 1'b1, 8'h0C);
        rdc(8'h51, 8'h0C);
        rx(16'h0099, 1'b0, 8'h00);
        cfg(2'h2, 1'b1);
        rx(16'h5678, 1'b1, 8'h0D);
        cfg(2'h0, 1'b1);
        rx(16'h0099, 1'b1, 8'h08);
        $display("receive test done");
        @(posedge clk);
        ce <= 1'b0;
        wr(8'h40, 8'hEE);
        @(posedge clk);
        ce <= 1'b1;
        rdc(8'h40, 8'h34);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdc(8'h40, 8'h00);
        rdc(8'h50, 8'h00);
        chk(rx_accept, 16'h0000);
        chk(tx_addr, 16'h0000);
        $display("enable and reset test done");
        wrap_up();
    end
endmodule : tb_top
